// ==== bench/flash_seclib_unlock_and_crc_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module flash_seclib_unlock_and_crc_tb;
    import fsuc_pkg::*;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, flash_ack;
    logic awready, wready, bvalid, arready, rvalid, flash_rd, busy, irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, flash_addr, flash_rdata, d, crc;
    logic [1:0] bresp, rresp, r;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;
    fsuc_top uut (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .flash_addr(flash_addr), .flash_rd(flash_rd),
        .flash_ack(flash_ack), .flash_rdata(flash_rdata), .checksum_busy(busy), .irq(irq));
    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    // flash answers one cycle late; idle data differs from any answer
    always @(posedge aclk)
    begin
        flash_ack <= flash_rd;
        flash_rdata <= flash_rd ? ~flash_addr : flash_addr;
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            failures++;
            print_verdict();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic axi_write(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (!bvalid);
        // ready comes a cycle late so the response has to stand
        bready <= 1'b1;
        @(posedge aclk);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic axi_read(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b1;
        @(posedge aclk);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        axi_read(a);
        check(d, exp);
    endtask
    task automatic do_reset();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
    endtask
    // msb-first crc of one word, no final inversion
    function automatic logic [31:0] crc_word(input logic [31:0] c, input logic [31:0] w);
        for (int i = 31; i >= 0; i--)
            c = (c[31] ^ w[i]) ? ({c[30:0], 1'b0} ^ CRC_POLY) : {c[30:0], 1'b0};
        return c;
    endfunction
    task automatic print_verdict();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
        aresetn = 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(ADDR_REGION_STS, 32'hFFFFFFFF);
        rd_chk(ADDR_EXTRA_STS, 32'h00000000);
        rd_chk(ADDR_CKS_RESULT, 32'h00000000);
        axi_read(8'h40);
        check({30'h0, r}, {30'h0, RESP_SLVERR});
        axi_write(8'h40, WORD_ZERO);
        check({30'h0, r}, {30'h0, RESP_SLVERR});
        axi_write(ADDR_IRQ_MASK, 32'h00000007);
        check({30'h0, r}, {30'h0, RESP_OKAY});
        axi_write(ADDR_PWD_ENTRY, WORD_ONES);
        rd_chk(ADDR_EXTRA_STS, 32'h00000000);
        axi_write(ADDR_PWD_ENTRY, 32'h00000005);
        rd_chk(ADDR_EXTRA_STS, 32'h00000001);
        check({31'h0, irq}, 32'h00000001);
        rd_chk(ADDR_IRQ_STS, 32'h00000002);
        check({31'h0, irq}, 32'h00000000);
        axi_write(ADDR_PWD_ENTRY, PWD_RESET);
        rd_chk(ADDR_EXTRA_STS, 32'h00000001);
        $display("test lockout done");
        do_reset();
        axi_write(ADDR_PWD_ENTRY, PWD_RESET);
        rd_chk(ADDR_EXTRA_STS, 32'h00000006);
        axi_write(ADDR_REGION_CFG, 32'h0FFFF81F);
        rd_chk(ADDR_REGION_STS, 32'h0FFFF81F);
        axi_write(ADDR_PWD_SET, 32'h12345678);
        axi_write(ADDR_PWD_SET, WORD_ZERO);
        axi_write(ADDR_PWD_ENTRY, WORD_ZERO);
        axi_read(ADDR_EXTRA_STS);
        check({31'h0, d[ERR_BIT]}, 32'h00000001);
        $display("test unlock done");
        do_reset();
        axi_write(ADDR_CKS_ADDR, 32'h00000400);
        rd_chk(ADDR_CKS_ADDR, 32'h00000000);
        axi_write(ADDR_CKS_CTRL, 32'h00010002);
        rd_chk(ADDR_CKS_RESULT, RESULT_RESET);
        crc = CRC_INIT;
        for (int i = 0; i < 512; i++)
            crc = crc_word(crc, ~(32'h00000400 + 32'(i) * WORD_BYTES));
        do
            @(posedge aclk);
        while (busy);
        rd_chk(ADDR_CKS_RESULT, crc);
        rd_chk(ADDR_CKS_CTRL, 32'h00000000);
        check({31'h0, irq}, 32'h00000000);
        rd_chk(ADDR_IRQ_STS, 32'h00000004);
        axi_write(ADDR_CKS_CTRL, 32'h00010000);
        rd_chk(ADDR_CKS_RESULT, 32'hFFFFFFFF);
        $display("test checksum done");
        print_verdict();
    end
endmodule
`default_nettype wire

// ==== bench/fsuc_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
module fsuc_checker
    import fsuc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] flash_addr,
    input wire logic flash_rd,
    input wire logic flash_ack,
    input wire logic checksum_busy
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ****************************************
    // helper: last requested flash word
    // ****************************************
    logic seen_q;
    logic [31:0] last_q;
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !checksum_busy)
            seen_q <= 1'b0;
        else if (flash_rd)
            seen_q <= 1'b1;
    end
    always_ff @(posedge aclk)
    begin
        if (flash_rd)
            last_q <= flash_addr;
    end
    sequence wr_both_s;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_wo_s;
        s_axi_arvalid && s_axi_arready
            && (s_axi_araddr == ADDR_CKS_ADDR || s_axi_araddr == ADDR_PWD_ENTRY);
    endsequence
    // ****************************************
    // assertions
    // ****************************************
    wo_read_zero_a: assert property (rd_wo_s |=> s_axi_rdata == WORD_ZERO)
        else $error("write-only register read back nonzero");
    read_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before rready");
    read_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    write_answer_a: assert property (wr_both_s |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    rd_pulse_a: assert property (flash_rd |=> !flash_rd)
        else $error("flash request longer than one cycle");
    addr_hold_a: assert property (checksum_busy && !flash_ack && !flash_rd
        |=> $stable(flash_addr))
        else $error("flash address moved while waiting");
    addr_step_a: assert property (flash_rd && seen_q
        |-> flash_addr == last_q + WORD_BYTES)
        else $error("flash words not sequential");
    busy_start_a: assert property ($rose(checksum_busy) |-> flash_rd)
        else $error("checksum start without a flash request");
endmodule
bind fsuc_top fsuc_checker chk (.aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .flash_addr, .flash_rd, .flash_ack, .checksum_busy);
`default_nettype wire

// ==== src/fsuc_pkg.sv ====
`default_nettype none
package fsuc_pkg;
    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [7:0] ADDR_REGION_STS = 8'h00;
    localparam logic [7:0] ADDR_PWD_ENTRY = 8'h04;
    localparam logic [7:0] ADDR_EXTRA_STS = 8'h08;
    localparam logic [7:0] ADDR_CKS_ADDR = 8'h0C;
    localparam logic [7:0] ADDR_CKS_CTRL = 8'h10;
    localparam logic [7:0] ADDR_CKS_RESULT = 8'h14;
    localparam logic [7:0] ADDR_IRQ_STS = 8'h18;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C;
    localparam logic [7:0] ADDR_PWD_SET = 8'h20;
    localparam logic [7:0] ADDR_REGION_CFG = 8'h24;
    // ****************************************
    // fields
    // ****************************************
    localparam int ES_LSB = 22;
    localparam int ISS_LSB = 11;
    localparam int ISS_W = 11;
    localparam int SS_W = 11;
    localparam int ES_W = 10;
    localparam logic [9:0] ES_RESET = 10'h3FF;
    localparam logic [10:0] ISS_RESET = 11'h7FF;
    localparam logic [10:0] SS_RESET = 11'h7FF;
    localparam logic [9:0] LAST_SECTOR_32K = 10'h01F;
    localparam logic [9:0] LAST_SECTOR_64K = 10'h03F;
    localparam int ERR_BIT = 0;
    localparam int OK_BIT = 1;
    localparam int ULK_BIT = 2;
    localparam int GO_BIT = 16;
    localparam int CNT_W = 16;
    localparam logic [31:0] WORD_ONES = 32'hFFFFFFFF;
    localparam logic [31:0] WORD_ZERO = 32'h00000000;
    localparam logic [31:0] RESULT_RESET = 32'h00000000;
    localparam logic [31:0] PWD_RESET = 32'h00000000;
    localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
    localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
    // 1 KB sectors of 32-bit words
    localparam logic [31:0] SECTOR_BYTES = 32'h00000400;
    localparam int WORDS_W = 8;
    localparam logic [7:0] WORDS_LAST = 8'hFF;
    localparam logic [31:0] WORD_BYTES = 32'h00000004;
    localparam int IRQ_W = 3;
    localparam int IRQ_OK = 0;
    localparam int IRQ_ERR = 1;
    localparam int IRQ_DONE = 2;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [2:0]
    {
        FSUC_IDLE = 3'b001,
        FSUC_REQ = 3'b010,
        FSUC_WAIT = 3'b100
    } fsuc_state_e;
endpackage
`default_nettype wire

// ==== src/fsuc_top.sv ====
// Function
// - end sector field bits 31:22, resets ones
// - exec-only start field 21:11, ones means none
// - first sector field 10:0, resets ones
// - sector 31 ends 32K, 63 ends 64K
// - password entry compared against stored password
// - entry outcome shown in status bits 0,1
// - unlocked flag bit 2 allows setting password and region registers
// - match sets password accepted flag
// - mismatch sets error unless all ones written
// - after error, entries ignored until reset
// - checksum start address write-only, reads zero
// - go bit 16 launches, clears itself
// - 16-bit sector count spans checksum
// - checksum result read-only, resets zero
// - new password only when unlocked, not 0/ones
`timescale 1ns/10ps
`default_nettype none
module fsuc_top
    import fsuc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] flash_addr,
    output logic flash_rd,
    input wire logic flash_ack,
    input wire logic [31:0] flash_rdata,
    output logic checksum_busy,
    output logic irq
);
    import fsuc_pkg::*;

    // ****************************************
    // write channel capture
    // ****************************************
    logic aw_hold_q;
    logic w_hold_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_fire;
    logic wr_known;

    assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
    assign s_axi_wready = !w_hold_q && !s_axi_bvalid;
    assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else if (clk_en)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_comb
    begin
        case (aw_addr_q)
            ADDR_PWD_ENTRY, ADDR_CKS_ADDR, ADDR_CKS_CTRL, ADDR_IRQ_MASK,
            ADDR_PWD_SET, ADDR_REGION_CFG:
                wr_known = 1'b1;
            default:
                wr_known = 1'b0;
        endcase
    end

    // full-word writes only: partial strobes would corrupt keys
    logic wr_full;
    assign wr_full = (w_strb_q == 4'hF);

    // ****************************************
    // protected region and password
    // ****************************************
    logic [ES_W-1:0] end_sector_q;
    logic [ISS_W-1:0] exec_first_q;
    logic [SS_W-1:0] first_sector_q;
    logic [31:0] stored_pwd_q;
    logic pwd_ok_q;
    logic pwd_err_q;
    logic unlocked_q;
    logic pwd_write;
    logic pwd_match;
    logic pwd_mismatch;

    assign pwd_write = wr_fire && wr_full && (aw_addr_q == ADDR_PWD_ENTRY);
    // error locks further entries out until reset
    assign pwd_match = pwd_write && !pwd_err_q && (w_data_q == stored_pwd_q);
    assign pwd_mismatch = pwd_write && !pwd_err_q && (w_data_q != stored_pwd_q)
        && (w_data_q != WORD_ONES);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pwd_ok_q <= 1'b0;
            pwd_err_q <= 1'b0;
            unlocked_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (pwd_match)
            begin
                pwd_ok_q <= 1'b1;
                unlocked_q <= 1'b1;
            end
            if (pwd_mismatch)
            begin
                pwd_err_q <= 1'b1;
            end
        end
    end

    // stored password survives only reset to zero: no nonvolatile store here
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            stored_pwd_q <= PWD_RESET;
        end
        else if (clk_en && wr_fire && wr_full && (aw_addr_q == ADDR_PWD_SET) && unlocked_q
            && (w_data_q != WORD_ONES) && (w_data_q != WORD_ZERO))
        begin
            stored_pwd_q <= w_data_q;
        end
    end

    // range fields load only while unlocked, and only within the 64K part
    logic [ES_W-1:0] cfg_es;
    logic [ISS_W-1:0] cfg_iss;
    logic [SS_W-1:0] cfg_ss;
    logic cfg_valid;
    assign cfg_es = w_data_q[31:ES_LSB];
    assign cfg_iss = w_data_q[ES_LSB-1:ISS_LSB];
    assign cfg_ss = w_data_q[ISS_LSB-1:0];
    assign cfg_valid = (cfg_es <= LAST_SECTOR_64K)
        && (cfg_ss <= {1'b0, LAST_SECTOR_64K})
        && ((cfg_iss <= {1'b0, LAST_SECTOR_64K}) || (cfg_iss == ISS_RESET));

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            end_sector_q <= ES_RESET;
            exec_first_q <= ISS_RESET;
            first_sector_q <= SS_RESET;
        end
        else if (clk_en && wr_fire && wr_full && (aw_addr_q == ADDR_REGION_CFG) && unlocked_q
            && cfg_valid)
        begin
            end_sector_q <= cfg_es;
            exec_first_q <= cfg_iss;
            first_sector_q <= cfg_ss;
        end
    end

    // ****************************************
    // checksum engine
    // ****************************************
    fsuc_state_e state_q;
    logic [31:0] cks_addr_q;
    logic [31:0] walk_addr_q;
    logic [CNT_W-1:0] sectors_left_q;
    logic [WORDS_W-1:0] word_idx_q;
    logic [31:0] crc_q;
    logic [31:0] result_q;
    logic done_pulse;
    logic go_write;
    logic [31:0] crc_next;

    assign go_write = wr_fire && wr_full && (aw_addr_q == ADDR_CKS_CTRL)
        && w_data_q[GO_BIT];

    always_comb
    begin
        crc_next = crc_q ^ flash_rdata;
        for (int i = 0; i < 32; i++)
        begin
            crc_next = crc_next[31] ? ((crc_next << 1) ^ CRC_POLY) : (crc_next << 1);
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cks_addr_q <= 32'h00000000;
        end
        else if (clk_en && wr_fire && wr_full && (aw_addr_q == ADDR_CKS_ADDR))
        begin
            cks_addr_q <= w_data_q;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_q <= FSUC_IDLE;
            walk_addr_q <= 32'h00000000;
            sectors_left_q <= '0;
            word_idx_q <= '0;
            crc_q <= CRC_INIT;
            result_q <= RESULT_RESET;
            done_pulse <= 1'b0;
        end
        else if (clk_en)
        begin
            done_pulse <= 1'b0;
            case (state_q)
                FSUC_IDLE:
                begin
                    // go is a pulse, never stored: it reads back as zero
                    if (go_write)
                    begin
                        sectors_left_q <= w_data_q[CNT_W-1:0];
                        walk_addr_q <= cks_addr_q;
                        word_idx_q <= '0;
                        crc_q <= CRC_INIT;
                        if (w_data_q[CNT_W-1:0] == '0)
                        begin
                            result_q <= CRC_INIT;
                            done_pulse <= 1'b1;
                        end
                        else
                        begin
                            state_q <= FSUC_REQ;
                        end
                    end
                end
                FSUC_REQ:
                begin
                    state_q <= FSUC_WAIT;
                end
                FSUC_WAIT:
                begin
                    if (flash_ack)
                    begin
                        crc_q <= crc_next;
                        walk_addr_q <= walk_addr_q + WORD_BYTES;
                        word_idx_q <= word_idx_q + 8'h01;
                        if (word_idx_q == WORDS_LAST)
                        begin
                            sectors_left_q <= sectors_left_q - 16'h0001;
                            if (sectors_left_q == 16'h0001)
                            begin
                                result_q <= crc_next;
                                done_pulse <= 1'b1;
                                state_q <= FSUC_IDLE;
                            end
                            else
                            begin
                                state_q <= FSUC_REQ;
                            end
                        end
                        else
                        begin
                            state_q <= FSUC_REQ;
                        end
                    end
                end
                default:
                begin
                    state_q <= FSUC_IDLE;
                end
            endcase
        end
    end

    assign flash_addr = walk_addr_q;
    assign flash_rd = (state_q == FSUC_REQ);
    assign checksum_busy = (state_q != FSUC_IDLE);

    // ****************************************
    // interrupts and read channel
    // ****************************************
    logic [IRQ_W-1:0] irq_sts_q;
    logic [IRQ_W-1:0] irq_mask_q;
    logic [IRQ_W-1:0] irq_set;
    logic irq_clear;
    logic [31:0] rd_word;
    logic rd_known;

    assign irq_set = {done_pulse, pwd_mismatch, pwd_match};
    assign irq_clear = s_axi_arvalid && s_axi_arready && (s_axi_araddr == ADDR_IRQ_STS);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_sts_q <= '0;
            irq_mask_q <= '0;
        end
        else if (clk_en)
        begin
            // a new event in the clearing cycle survives the read
            irq_sts_q <= (irq_clear ? '0 : irq_sts_q) | irq_set;
            if (wr_fire && wr_full && (aw_addr_q == ADDR_IRQ_MASK))
            begin
                irq_mask_q <= w_data_q[IRQ_W-1:0];
            end
        end
    end

    assign irq = |(irq_sts_q & irq_mask_q);

    always_comb
    begin
        rd_word = 32'h00000000;
        rd_known = 1'b1;
        case (s_axi_araddr)
            ADDR_REGION_STS:
                rd_word = {end_sector_q, exec_first_q, first_sector_q};
            ADDR_EXTRA_STS:
            begin
                rd_word[ULK_BIT] = unlocked_q;
                rd_word[OK_BIT] = pwd_ok_q;
                rd_word[ERR_BIT] = pwd_err_q;
            end
            ADDR_CKS_RESULT:
                rd_word = result_q;
            ADDR_IRQ_STS:
                rd_word[IRQ_W-1:0] = irq_sts_q;
            ADDR_IRQ_MASK:
                rd_word[IRQ_W-1:0] = irq_mask_q;
            ADDR_PWD_ENTRY, ADDR_CKS_ADDR, ADDR_CKS_CTRL, ADDR_PWD_SET, ADDR_REGION_CFG:
                rd_word = 32'h00000000;
            default:
                rd_known = 1'b0;
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (clk_en)
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire
